/* hdl/dnc_pkg.sv */
// constants, opcodes and boot program of the fixed-point audio core
package dnc_pkg;
  // ****************************************
  // word widths
  // ****************************************
  localparam int AUD_W = 24;
  localparam int CORE_W = 28;
  localparam int ACC_W = 56;
  localparam int FRAC_W = 23;
  localparam int PARAM_W = 32;
  localparam int INSTR_W = 40;
  localparam int ADDR_W = 12;
  localparam int PARAM_AW = 10;
  localparam int PROG_AW = 9;
  localparam int DATA_AW = 9;
  // ****************************************
  // memory map
  // ****************************************
  localparam int PARAM_DEPTH = 1024;
  localparam int PROG_DEPTH = 512;
  localparam int DATA_DEPTH = 512;
  localparam logic [11:0] PARAM_BASE = 12'h000;
  localparam logic [11:0] PROG_BASE = 12'h400;
  localparam logic [11:0] RSVD_BASE = 12'h600;
  localparam logic [11:0] RSVD_END = 12'h7ff;
  localparam logic [3:0] PARAM_PAD = 4'h0;
  // ****************************************
  // safeload and sequencing
  // ****************************************
  localparam int SL_SLOTS = 5;
  localparam int SL_IW = 3;
  localparam logic [9:0] INSTR_PER_SAMPLE = 10'h200;
  localparam logic [1:0] RATE_SINGLE = 2'h0;
  localparam logic [1:0] RATE_DOUBLE = 2'h1;
  localparam logic [1:0] RATE_QUAD = 2'h2;
  // ****************************************
  // instruction fields and opcodes
  // ****************************************
  localparam int OPC_HI = 39;
  localparam int OPC_LO = 36;
  localparam int PA_HI = 35;
  localparam int PA_LO = 26;
  localparam int DA_HI = 25;
  localparam int DA_LO = 17;
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_LDIN = 4'h1;
  localparam logic [3:0] OP_MPY = 4'h2;
  localparam logic [3:0] OP_MAC = 4'h3;
  localparam logic [3:0] OP_STORE = 4'h4;
  localparam logic [3:0] OP_LDDATA = 4'h5;
  localparam logic [3:0] OP_OUT = 4'h6;
  localparam logic [22:0] LSB_FILL = 23'h000000;
  localparam logic [23:0] CLIP_POS = 24'h7fffff;
  localparam logic [23:0] CLIP_NEG = 24'h800000;

  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_RUN} dnc_state_t;

  // built-in program: pass the input straight to the output
  function automatic logic [INSTR_W-1:0] dnc_boot_rom(input logic [PROG_AW-1:0] idx);
    logic [INSTR_W-1:0] w;
    w = '0;
    if (idx == 9'h000) begin
      w[OPC_HI:OPC_LO] = OP_LDIN;
    end else if (idx == 9'h001) begin
      w[OPC_HI:OPC_LO] = OP_OUT;
    end
    return w;
  endfunction
endpackage

/* hdl/dnc_buf2.sv */
// two-entry output buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module dnc_buf2
  import dnc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  input wire logic [AUD_W-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [AUD_W-1:0] out_data,
  input wire logic out_ready
);
  logic [AUD_W-1:0] slot1, next_slot1, next_out_data;
  logic [1:0] cnt, next_cnt;
  logic next_out_valid, next_in_ready;
  logic push, pop;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_cnt = cnt;
    next_out_data = out_data;
    next_slot1 = slot1;
    if (push && !pop) begin
      next_cnt = cnt + 2'h1;
    end else if (pop && !push) begin
      next_cnt = cnt - 2'h1;
    end
    if (pop) begin
      next_out_data = (cnt == 2'h2) ? slot1 : in_data;
    end else if (push && cnt == 2'h0) begin
      next_out_data = in_data;
    end
    if (push && (cnt == 2'h2 || (cnt == 2'h1 && !pop))) begin
      next_slot1 = in_data;
    end
    next_out_valid = (next_cnt != 2'h0);
    next_in_ready = (next_cnt != 2'h2);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 2'h0;
      slot1 <= '0;
      out_data <= '0;
      out_valid <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      cnt <= next_cnt;
      slot1 <= next_slot1;
      out_data <= next_out_data;
      out_valid <= next_out_valid;
      in_ready <= next_in_ready;
    end
  end

  buf_no_loss_a: assert property (@(posedge clk) disable iff (rst)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffered word changed while stalled");
endmodule
`default_nettype wire

/* hdl/dnc_core.sv */
// fixed-point audio core: memories, safeload, sequencer, clipper
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - audio enters and leaves as 24 bits, carried internally as 28 bits
// - four headroom bits give 24 dB of internal gain without clipping
// - 28-bit products accumulate in a 56-bit accumulator
// - parameters and data share signed 5.23 fixed point
// - input samples are sign-extended to 28 bits
// - output passes a saturating clipper to 24 bits, range -1.0 to 1.0-lsb
// - built-in program passes input to output; output muted by default
// - 512 instructions run every sample period
// - double or quad rate runs fewer instructions, chosen by a field
// - parameter RAM is 32 bits wide at 0..1023, read and write
// - parameters are 28 bits right-aligned with four zero bits above
// - program RAM 0x400..0x5ff holds 40-bit words, direct writes only
// - 0x600..0x7ff reserved: reads give nothing, writes ignored
// - after power-up all RAM is zero except the built-in program; safeload slots are not cleared
// - program and parameter RAM load from boot contents before processing
// - direct parameter writes take the RAM from the core, no handshake
// - five safeload slots copy into parameter RAM only while it is idle
// - safeload targets parameter RAM only
// - 0.5k data RAM holds processing state, not host-addressable
// - delay lines step in whole samples, bounded by 512 locations
// - burst accesses increment the address across all region boundaries
module dnc_core
  import dnc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic [1:0] rate_sel,
  input wire logic unmute,
  output logic boot_done,
  // host direct access
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic host_new,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [INSTR_W-1:0] host_wdata,
  output logic [INSTR_W-1:0] host_rdata,
  output logic host_rvalid,
  // safeload
  input wire logic sl_wr,
  input wire logic [SL_IW-1:0] sl_slot,
  input wire logic [PARAM_AW-1:0] sl_addr,
  input wire logic [CORE_W-1:0] sl_data,
  input wire logic sl_commit,
  // audio in
  input wire logic in_valid,
  input wire logic [AUD_W-1:0] in_sample,
  output logic in_ready,
  // audio out
  output logic out_valid,
  output logic [AUD_W-1:0] out_data,
  input wire logic out_ready
);
  // ****************************************
  // arithmetic helpers
  // ****************************************
  function automatic logic [CORE_W-1:0] sext_in(input logic [AUD_W-1:0] s);
    return {{(CORE_W-AUD_W){s[AUD_W-1]}}, s};
  endfunction
  // keep 5.23 out of the 10.46 accumulator, saturating on overflow
  function automatic logic [CORE_W-1:0] acc_to_core(input logic [ACC_W-1:0] a);
    logic [CORE_W-1:0] r;
    r = a[FRAC_W+CORE_W-1:FRAC_W];
    if (a[ACC_W-1:FRAC_W+CORE_W-1] != {(ACC_W-FRAC_W-CORE_W+1){a[ACC_W-1]}}) begin
      r = {a[ACC_W-1], {(CORE_W-1){~a[ACC_W-1]}}};
    end
    return r;
  endfunction
  function automatic logic [AUD_W-1:0] clip24(input logic [CORE_W-1:0] c);
    logic [AUD_W-1:0] r;
    r = c[AUD_W-1:0];
    if (c[CORE_W-1:AUD_W-1] != {(CORE_W-AUD_W+1){c[CORE_W-1]}}) begin
      r = c[CORE_W-1] ? CLIP_NEG : CLIP_POS;
    end
    return r;
  endfunction
  function automatic logic [ACC_W-1:0] core_to_acc(input logic [CORE_W-1:0] c);
    return {{(ACC_W-CORE_W-FRAC_W){c[CORE_W-1]}}, c, LSB_FILL};
  endfunction
  function automatic logic [9:0] instr_limit(input logic [1:0] r);
    logic [9:0] n;
    n = INSTR_PER_SAMPLE;
    if (r == RATE_DOUBLE) begin
      n = INSTR_PER_SAMPLE >> 1;
    end else if (r == RATE_QUAD) begin
      n = INSTR_PER_SAMPLE >> 2;
    end
    return n;
  endfunction

  // ****************************************
  // storage
  // ****************************************
  logic [CORE_W-1:0] param_mem [PARAM_DEPTH];
  logic [INSTR_W-1:0] prog_mem [PROG_DEPTH];
  logic [CORE_W-1:0] data_mem [DATA_DEPTH];
  logic [PARAM_AW-1:0] sl_a [SL_SLOTS];
  logic [CORE_W-1:0] sl_d [SL_SLOTS];

  // ****************************************
  // state and next values
  // ****************************************
  dnc_state_t state, next_state;
  logic [PARAM_AW-1:0] boot_idx, next_boot_idx;
  logic next_boot_done;
  logic [PROG_AW-1:0] pc, next_pc;
  logic [DATA_AW-1:0] frame_base, next_frame_base;
  logic [ACC_W-1:0] acc, next_acc;
  logic [CORE_W-1:0] in_reg, next_in_reg;
  logic [ADDR_W-1:0] ptr, next_ptr;
  logic [INSTR_W-1:0] next_host_rdata;
  logic next_host_rvalid, next_in_ready;
  logic [SL_SLOTS-1:0] sl_pend, next_sl_pend;
  logic sl_armed, next_sl_armed;
  logic muted, next_muted;

  // ****************************************
  // decode and datapath
  // ****************************************
  logic [INSTR_W-1:0] instr;
  logic [3:0] opc;
  logic [PARAM_AW-1:0] pa;
  logic [DATA_AW-1:0] da;
  logic [CORE_W-1:0] prm, dat;
  logic [ACC_W-1:0] prod;
  logic [ADDR_W-1:0] ea;
  logic host_param_wr, host_prog_wr, sl_fire, stall, last_instr;
  logic push;
  logic [AUD_W-1:0] push_data;
  logic buf_ready;
  logic [9:0] limit;
  always_comb begin
    instr = prog_mem[pc];
    opc = instr[OPC_HI:OPC_LO];
    pa = instr[PA_HI:PA_LO];
    // circular offset turns a fixed address into a delay tap, one sample per address step
    da = instr[DA_HI:DA_LO] + frame_base;
    ea = host_new ? host_addr : ptr;
    host_param_wr = host_wr && boot_done && ea < PROG_BASE;
    host_prog_wr = host_wr && boot_done && ea >= PROG_BASE && ea < RSVD_BASE;
    // a direct write steals the port; the core sees zero that cycle
    prm = host_param_wr ? '0 : param_mem[pa];
    dat = data_mem[da];
    prod = ACC_W'($signed(dat) * $signed(prm));
    limit = instr_limit(rate_sel);
    last_instr = ({1'b0, pc} == limit - 10'h001);
    push = (state == ST_RUN) && opc == OP_OUT && buf_ready;
    push_data = muted ? '0 : clip24(acc_to_core(acc));
    stall = (state == ST_RUN) && opc == OP_OUT && !buf_ready;
    // commit only between frames, all slots in the same cycle
    sl_fire = (state == ST_IDLE) && sl_armed && !host_param_wr;
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    next_boot_idx = boot_idx;
    next_boot_done = boot_done;
    next_pc = pc;
    next_frame_base = frame_base;
    next_acc = acc;
    next_in_reg = in_reg;
    case (state)
      ST_BOOT: begin
        next_boot_idx = boot_idx + 10'h001;
        if (boot_idx == 10'h3ff) begin
          next_state = ST_IDLE;
          next_boot_done = 1'b1;
        end
      end
      ST_IDLE: begin
        if (in_valid && in_ready) begin
          next_in_reg = sext_in(in_sample);
          next_pc = '0;
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!stall) begin
          case (opc)
            OP_LDIN: next_acc = core_to_acc(in_reg);
            OP_LDDATA: next_acc = core_to_acc(dat);
            OP_MPY: next_acc = prod;
            OP_MAC: next_acc = acc + prod;
            default: next_acc = acc;
          endcase
          next_pc = pc + 9'h001;
          if (last_instr) begin
            next_state = ST_IDLE;
            next_frame_base = frame_base - 9'h001;
          end
        end
      end
      default: next_state = ST_BOOT;
    endcase
    next_in_ready = (next_state == ST_IDLE);
    next_muted = !unmute;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_BOOT;
      boot_idx <= '0;
      boot_done <= 1'b0;
      pc <= '0;
      frame_base <= '0;
      acc <= '0;
      in_reg <= '0;
      in_ready <= 1'b0;
      muted <= 1'b1;
    end else begin
      state <= next_state;
      boot_idx <= next_boot_idx;
      boot_done <= next_boot_done;
      pc <= next_pc;
      frame_base <= next_frame_base;
      acc <= next_acc;
      in_reg <= next_in_reg;
      in_ready <= next_in_ready;
      muted <= next_muted;
    end
  end

  // ****************************************
  // host port and safeload slots
  // ****************************************
  always_comb begin
    next_ptr = ptr;
    next_host_rvalid = 1'b0;
    next_host_rdata = host_rdata;
    if ((host_wr || host_rd) && boot_done) begin
      next_ptr = ea + 12'h001;
    end
    if (host_rd && boot_done) begin
      next_host_rvalid = 1'b1;
      next_host_rdata = '0;
      if (ea < PROG_BASE) begin
        next_host_rdata = {8'h00, PARAM_PAD, param_mem[ea[PARAM_AW-1:0]]};
      end else if (ea < RSVD_BASE) begin
        next_host_rdata = prog_mem[ea[PROG_AW-1:0]];
      end
    end
    next_sl_pend = sl_fire ? '0 : sl_pend;
    if (sl_wr && sl_slot < SL_IW'(SL_SLOTS)) begin
      next_sl_pend[sl_slot] = 1'b1;
    end
    // an arm that lands with the commit survives it
    next_sl_armed = (sl_armed && !sl_fire) || sl_commit;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr <= '0;
      host_rvalid <= 1'b0;
      host_rdata <= '0;
      sl_pend <= '0;
      sl_armed <= 1'b0;
    end else begin
      ptr <= next_ptr;
      host_rvalid <= next_host_rvalid;
      host_rdata <= next_host_rdata;
      sl_pend <= next_sl_pend;
      sl_armed <= next_sl_armed;
    end
  end
  // memories have no reset; the boot walk fills them
  always_ff @(posedge clk) begin
    if (state == ST_BOOT) begin
      param_mem[boot_idx] <= '0;
      if (boot_idx < 10'(PROG_DEPTH)) begin
        prog_mem[boot_idx[PROG_AW-1:0]] <= dnc_boot_rom(boot_idx[PROG_AW-1:0]);
        data_mem[boot_idx[DATA_AW-1:0]] <= '0;
      end
    end else begin
      if (host_param_wr) begin
        param_mem[ea[PARAM_AW-1:0]] <= host_wdata[CORE_W-1:0];
      end
      if (host_prog_wr) begin
        prog_mem[ea[PROG_AW-1:0]] <= host_wdata;
      end
      for (int i = 0; i < SL_SLOTS; i++) begin
        if (sl_fire && sl_pend[i]) begin
          param_mem[sl_a[i]] <= sl_d[i];
        end
      end
      if (state == ST_RUN && !stall && opc == OP_STORE) begin
        data_mem[da] <= acc_to_core(acc);
      end
    end
    if (sl_wr && sl_slot < SL_IW'(SL_SLOTS)) begin
      sl_a[sl_slot] <= sl_addr;
      sl_d[sl_slot] <= sl_data;
    end
  end

  // ****************************************
  // output buffer
  // ****************************************
  dnc_buf2 u_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_data(push_data),
    .in_ready(buf_ready),
    .out_valid(out_valid),
    .out_data(out_data),
    .out_ready(out_ready)
  );

  // ****************************************
  // checks
  // ****************************************
  logic [10:0] run_cnt;
  always_ff @(posedge clk) begin
    if (rst || state != ST_RUN) begin
      run_cnt <= '0;
    end else if (!stall) begin
      run_cnt <= run_cnt + 11'h001;
    end
  end
  sequence frame_start_s;
    state == ST_IDLE && in_valid && in_ready;
  endsequence
  sequence frame_end_s;
    state == ST_RUN && !stall && last_instr;
  endsequence
  sign_extend_a: assert property (@(posedge clk) disable iff (rst)
    frame_start_s |=> in_reg[CORE_W-1:AUD_W] == {4{$past(in_sample[AUD_W-1])}})
    else $error("input sample not sign-extended");
  clip_range_a: assert property (@(posedge clk) disable iff (rst)
    push && !muted && $signed(acc_to_core(acc)) > $signed({5'h00, CLIP_POS[22:0]})
    |-> push_data == CLIP_POS)
    else $error("positive overflow not clipped");
  mute_out_a: assert property (@(posedge clk) disable iff (rst)
    push && muted |-> push_data == '0)
    else $error("muted output not zero");
  instr_budget_a: assert property (@(posedge clk) disable iff (rst)
    frame_end_s |-> run_cnt + 11'h001 == {1'b0, limit})
    else $error("frame ran wrong instruction count");
  boot_walk_a: assert property (@(posedge clk)
    $fell(rst) |-> !boot_done [*8] ##1 !in_ready)
    else $error("processing began before boot load");
  reserved_read_a: assert property (@(posedge clk) disable iff (rst)
    host_rd && boot_done && ea >= RSVD_BASE |=> host_rvalid && host_rdata == '0)
    else $error("reserved read returned data");
  param_pad_a: assert property (@(posedge clk) disable iff (rst)
    host_rd && boot_done && ea < PROG_BASE |=> host_rdata[PARAM_W-1:CORE_W] == PARAM_PAD)
    else $error("parameter read not zero padded");
  burst_step_a: assert property (@(posedge clk) disable iff (rst)
    (host_wr || host_rd) && boot_done |=> ptr == $past(ea) + 12'h001)
    else $error("burst address did not advance");
  sl_idle_a: assert property (@(posedge clk) disable iff (rst)
    sl_armed && state == ST_RUN |=> sl_armed)
    else $error("safeload committed while core busy");
  sl_atomic_a: assert property (@(posedge clk) disable iff (rst)
    sl_fire && !sl_wr |=> sl_pend == '0)
    else $error("safeload slots left pending after commit");
endmodule
`default_nettype wire

/* verification/dnc_host_model.sv */
// host controller model: direct memory accesses and safeload slots
`timescale 1ns/1ns
`default_nettype none
module dnc_host_model
  import dnc_pkg::*;
(
  // clock
  input wire logic clk,
  // direct access
  output logic host_wr,
  output logic host_rd,
  output logic host_new,
  output logic [ADDR_W-1:0] host_addr,
  output logic [INSTR_W-1:0] host_wdata,
  input wire logic [INSTR_W-1:0] host_rdata,
  input wire logic host_rvalid,
  // safeload
  output logic sl_wr,
  output logic [SL_IW-1:0] sl_slot,
  output logic [PARAM_AW-1:0] sl_addr,
  output logic [CORE_W-1:0] sl_data,
  output logic sl_commit
);
  // ****************************************
  // idle levels
  // ****************************************
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_new = 1'b0;
    host_addr = '0;
    host_wdata = '0;
    sl_wr = 1'b0;
    sl_slot = '0;
    sl_addr = '0;
    sl_data = '0;
    sl_commit = 1'b0;
  end
  // ****************************************
  // access tasks
  // ****************************************
  // one word per cycle; only the first word names its address, the rest ride the pointer
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [INSTR_W-1:0] d [6], input int n,
      output logic [INSTR_W-1:0] q [6], output int misses);
    misses = 0;
    for (int i = 0; i <= n; i++) begin
      @(negedge clk);
      if (i > 0 && !wr) begin
        if (host_rvalid !== 1'b1) misses++;
        q[i-1] = host_rdata;
      end
      host_new = (i == 0);
      host_wr = wr && (i < n);
      host_rd = !wr && (i < n);
      // released lines flip so a stale value cannot pass for a driven one
      host_addr = (i < n) ? a : ~host_addr;
      host_wdata = (i < n) ? d[i] : ~host_wdata;
    end
  endtask

  task automatic sl_load(input logic [SL_IW-1:0] s, input logic [PARAM_AW-1:0] a,
      input logic [CORE_W-1:0] v);
    @(negedge clk);
    sl_wr = 1'b1;
    sl_slot = s;
    sl_addr = a;
    sl_data = v;
    @(negedge clk);
    sl_wr = 1'b0;
    sl_addr = ~a;
    sl_data = ~v;
  endtask

  task automatic sl_go();
    @(negedge clk);
    sl_commit = 1'b1;
    @(negedge clk);
    sl_commit = 1'b0;
  endtask
endmodule
`default_nettype wire

/* verification/dsp_numeric_core_and_ram_map_bench.sv */
// self-checking bench for the fixed-point audio core
`timescale 1ns/1ns
`default_nettype none
module dsp_numeric_core_and_ram_map_bench
  import dnc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] rate_sel = 2'h0;
  logic unmute = 1'b0;
  logic in_valid = 1'b0;
  logic [AUD_W-1:0] in_sample = '0;
  logic out_ready = 1'b0;
  logic boot_done, host_wr, host_rd, host_new, host_rvalid, sl_wr, sl_commit;
  logic in_ready, out_valid;
  logic [ADDR_W-1:0] host_addr;
  logic [INSTR_W-1:0] host_wdata, host_rdata;
  logic [SL_IW-1:0] sl_slot;
  logic [PARAM_AW-1:0] sl_addr;
  logic [CORE_W-1:0] sl_data;
  logic [AUD_W-1:0] out_data;
  logic [INSTR_W-1:0] d [6];
  logic [INSTR_W-1:0] q [6];
  int miss;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  localparam logic [INSTR_W-1:0] W_LDIN = {OP_LDIN, 36'h0};
  localparam logic [INSTR_W-1:0] W_OUT = {OP_OUT, 36'h0};

  dnc_core u_dut (.clk, .rst, .rate_sel, .unmute, .boot_done, .host_wr, .host_rd,
    .host_new, .host_addr, .host_wdata, .host_rdata, .host_rvalid, .sl_wr, .sl_slot,
    .sl_addr, .sl_data, .sl_commit, .in_valid, .in_sample, .in_ready, .out_valid,
    .out_data, .out_ready);
  dnc_host_model u_host (.clk, .host_wr, .host_rd, .host_new, .host_addr, .host_wdata,
    .host_rdata, .host_rvalid, .sl_wr, .sl_slot, .sl_addr, .sl_data, .sl_commit);

  always #10 clk = ~clk;

  // ****************************************
  // bookkeeping
  // ****************************************
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      err_count++;
      $display("CHECK FAILED at %0t: timeout", $time);
      complete_run();
    end
  end

  task automatic chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic send(input logic [AUD_W-1:0] s);
    int n;
    n = 0;
    @(negedge clk);
    while (in_ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk(n < 2000, "input never ready");
    in_valid = 1'b1;
    in_sample = s;
    @(negedge clk);
    in_valid = 1'b0;
    in_sample = ~s;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_boot();
    int n;
    n = 0;
    repeat (12) @(negedge clk);
    chk(boot_done === 1'b0 && in_ready === 1'b0 && out_valid === 1'b0, "reset outputs");
    rst = 1'b0;
    while (boot_done !== 1'b1 && n < 1100) begin
      @(negedge clk);
      n++;
    end
    chk(n == 1024, "boot length");
    u_host.access(1'b0, 12'h3fe, d, 5, q, miss);
    chk(miss == 0 && q[0] === '0 && q[1] === '0, "param not cleared");
    chk(q[2] === W_LDIN && q[3] === W_OUT && q[4] === '0, "boot program");
    $display("t_boot done");
  endtask

  task automatic t_audio();
    logic [AUD_W-1:0] exp [3];
    int n;
    exp = '{24'h7fffff, 24'h800000, 24'h0a5a5a};
    send(24'h123456);
    @(negedge clk);
    chk(out_valid === 1'b0, "word too early");
    @(negedge clk);
    chk(out_valid === 1'b1 && out_data === 24'h0, "muted word");
    out_ready = 1'b1;
    @(negedge clk);
    out_ready = 1'b0;
    unmute = 1'b1;
    for (int k = 0; k < 3; k++) send(exp[k]);
    // third word finds the buffer full, so its frame must hold
    repeat (600) @(negedge clk);
    chk(in_ready === 1'b0 && out_data === exp[0], "stall lost or passed");
    out_ready = 1'b1;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      while (out_valid !== 1'b1 && n < 100) begin
        @(negedge clk);
        n++;
      end
      chk(out_data === exp[k], "audio word");
      @(negedge clk);
    end
    $display("t_audio done");
  endtask

  task automatic t_map();
    d[0] = 40'h123f654321;
    d[1] = 40'ha55aa55aa5;
    u_host.access(1'b1, 12'h3ff, d, 2, q, miss);
    d[0] = '1;
    d[1] = '1;
    u_host.access(1'b1, 12'h600, d, 1, q, miss);
    u_host.access(1'b1, 12'h7ff, d, 2, q, miss);
    u_host.access(1'b0, 12'h3ff, d, 2, q, miss);
    chk(miss == 0 && q[0] === 40'h000f654321, "param word");
    chk(q[1] === 40'ha55aa55aa5, "program word across boundary");
    u_host.access(1'b0, 12'h600, d, 1, q, miss);
    chk(miss == 0 && q[0] === '0, "reserved read");
    u_host.access(1'b0, 12'h7ff, d, 2, q, miss);
    chk(miss == 0 && q[0] === '0 && q[1] === '0, "reserved or data ram read");
    d[0] = W_LDIN;
    u_host.access(1'b1, 12'h400, d, 1, q, miss);
    $display("t_map done");
  endtask

  task automatic t_safeload();
    int n;
    n = 0;
    u_host.sl_load(3'h0, 10'h020, 28'h0800000);
    u_host.sl_load(3'h1, 10'h021, 28'hf800000);
    u_host.sl_load(3'h2, 10'h021, 28'h7ffffff);
    u_host.sl_load(3'h5, 10'h022, 28'h1111111);
    u_host.access(1'b0, 12'h020, d, 1, q, miss);
    chk(q[0] === '0, "slot landed before commit");
    send(24'h000000);
    u_host.sl_go();
    u_host.access(1'b0, 12'h020, d, 1, q, miss);
    chk(q[0] === '0 && in_ready === 1'b0, "commit inside a frame");
    // commit waits for the gap between frames
    while (in_ready !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    u_host.access(1'b0, 12'h020, d, 3, q, miss);
    chk(q[0] === 40'h0000800000 && q[1] === 40'h0007ffffff, "committed slots");
    chk(q[2] === '0, "slot five taken");
    u_host.access(1'b0, 12'h400, d, 1, q, miss);
    chk(q[0] === W_LDIN, "program touched by safeload");
    $display("t_safeload done");
  endtask

  task automatic t_rate();
    int n;
    int lim;
    out_ready = 1'b1;
    for (int r = 0; r < 4; r++) begin
      rate_sel = 2'(r);
      lim = (r == 1) ? 256 : (r == 2) ? 128 : 512;
      send(24'h000100);
      n = 0;
      while (in_ready !== 1'b1 && n < 600) begin
        @(negedge clk);
        n++;
      end
      chk(n == lim, "frame length");
    end
    $display("t_rate done");
  endtask

  task automatic t_gain();
    logic [AUD_W-1:0] x [5];
    logic [AUD_W-1:0] y [5];
    int n;
    x = '{24'h300000, 24'h300000, 24'h080000, 24'hd00000, 24'hd00000};
    // gain 2.0 on the sample plus gain 2.0 on the one-sample delayed sample
    y = '{24'h600000, 24'h7fffff, 24'h700000, 24'hb00000, 24'h800000};
    rate_sel = 2'h2;
    d[0] = W_LDIN;
    d[1] = {OP_STORE, 36'h0};
    d[2] = {OP_MPY, 10'h010, 9'h000, 17'h00000};
    d[3] = {OP_MAC, 10'h010, 9'h001, 17'h00000};
    d[4] = W_OUT;
    u_host.access(1'b1, 12'h400, d, 5, q, miss);
    d[0] = 40'h0001000000;
    u_host.access(1'b1, 12'h010, d, 1, q, miss);
    for (int k = 0; k < 5; k++) begin
      send(x[k]);
      n = 0;
      while (out_valid !== 1'b1 && n < 20) begin
        @(negedge clk);
        n++;
      end
      chk(out_valid === 1'b1 && out_data === y[k], "gain word");
    end
    $display("t_gain done");
  endtask

  initial begin
    t_boot();
    t_audio();
    t_map();
    t_safeload();
    t_rate();
    t_gain();
    complete_run();
  end
endmodule
`default_nettype wire
